// *** core/psml_cfg.svh ***
// strap latch constants: field positions, reset values, fifo sizes
`ifndef PSML_CFG_SVH
`define PSML_CFG_SVH
`define PSML_REG_CTRL 12'h000
`define PSML_REG_STRAP 12'h004
`define PSML_REG_RANGE 12'h008
`define PSML_REG_TXDATA 12'h00C
`define PSML_REG_CFGIN 12'h010
`define PSML_CTRL_RESET_BIT 0
`define PSML_STRAP_BYTE_BIT 0
`define PSML_STRAP_SW_BIT 1
`define PSML_STRAP_ONE_BIT 2
`define PSML_STRAP_OS_LSB 4
`define PSML_STRAP_SER_BIT 8
`define PSML_OS_RESET 3'h0
`define PSML_FIFO_DEPTH 8
`define PSML_WORD_W 16
`endif

// *** core/psml_pkg.sv ***
// strap latch types
package psml_pkg;
    typedef enum logic [1:0] {
        PSML_RANGE_SW,
        PSML_RANGE_2V5,
        PSML_RANGE_5V,
        PSML_RANGE_10V
    } psml_range_t;
    typedef struct packed {
        logic byte_iface;
        logic sw_mode;
        logic serial_mode;
        logic single_out;
        logic [2:0] oversample;
        logic [1:0] sw_range;
    } psml_strap_t;
    typedef struct packed {
        logic [6:0] dout;
        logic [6:0] doe;
    } psml_pins_t;
    typedef enum logic [0:0] {
        PSML_IDLE,
        PSML_SHIFT
    } psml_state_t;
endpackage : psml_pkg

// *** core/psml_fifo.sv ***
// parameterised flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module psml_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] wr_next;
    logic [AW-1:0] rd_reg;
    logic [AW-1:0] rd_next;
    logic [AW:0] cnt_reg;
    logic [AW:0] cnt_next;
    logic push;
    logic pop;
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb
    begin
        mem_next = mem_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (push)
        begin
            mem_next[wr_reg] = in_data;
            wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
        end
        if (pop)
        begin
            rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
        end
        if (push && !pop)
        begin
            cnt_next = cnt_reg + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_next = cnt_reg - 1'b1;
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_reg[i] <= '0;
            end
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end
        else if (ce)
        begin
            mem_reg <= mem_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule : psml_fifo

// *** core/psml_top.sv ***
// pin strap latch, shared pin routing and apb control for the converter
//
// Functional notes
// - byte select pin latched at full reset
// - oversample pins latched, held until reset
// - range pins choose hardware or software mode
// - range pins 00 means software mode
// - hardware mode: range pins live, unlatched
// - codes 01/10/11 give 2.5/5/10 V
// - software mode: range pins latched, ignored after
// - parallel mode: shared pins are data 9..15
// - serial mode: results on output a
// - output b only when strap enables two
// - software serial: config bits on serial input
// - single output strap latched at full reset
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`include "psml_cfg.svh"
module psml_top #(
    parameter int WORD_W = `PSML_WORD_W,
    parameter int FIFO_DEPTH = `PSML_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic serial_mode_pin,
    input wire logic [1:0] range_mode_sel,
    input wire logic [6:0] shared_in,
    output logic [6:0] shared_out,
    output logic [6:0] shared_oe,
    input wire logic [6:0] par_wdata,
    input wire logic par_drive,
    output psml_pkg::psml_range_t range_sel,
    output psml_pkg::psml_strap_t strap,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // shared pin indices: 0=db9 byte select, 1=db10 cfg in, 2=db11 out b,
    // 3=db12 out a, 4..6=db13..15 oversample
    localparam int P_BYTE = 0;
    localparam int P_CFGIN = 1;
    localparam int P_OUTB = 2;
    localparam int P_OUTA = 3;
    localparam int P_OS = 4;
    localparam int CW = $clog2(WORD_W);

    logic full_rst_reg;
    logic full_rst_next;
    logic pend_reg;
    logic pend_next;
    psml_pkg::psml_strap_t strap_reg;
    psml_pkg::psml_strap_t strap_next;
    logic [WORD_W-1:0] sh_reg;
    logic [WORD_W-1:0] sh_next;
    logic [CW-1:0] bit_reg;
    logic [CW-1:0] bit_next;
    psml_pkg::psml_state_t st_reg;
    psml_pkg::psml_state_t st_next;
    logic [WORD_W-1:0] cfg_reg;
    logic [WORD_W-1:0] cfg_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic wr_acc;
    logic rd_acc;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [WORD_W-1:0] fifo_out_data;
    logic serial_act;
    logic byte_select;
    logic oversample_sel_0;
    logic oversample_sel_1;
    logic oversample_sel_2;
    logic single_output_sel;
    logic serial_cfg_in;
    logic pins_live;

    assign byte_select = shared_in[P_BYTE];
    assign oversample_sel_0 = shared_in[P_OS];
    assign oversample_sel_1 = shared_in[P_OS+1];
    assign oversample_sel_2 = shared_in[P_OS+2];
    assign single_output_sel = par_wdata[0];
    assign serial_cfg_in = shared_in[P_CFGIN];
    assign wr_acc = psel && penable && pwrite;
    // read data is taken at the setup edge so it stands at the access edge
    assign rd_acc = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_reg;

    // full reset: the async pin or a software reset pulse; straps captured
    // on the edge after it drops so a stuck bus value can never be latched
    always_comb
    begin
        full_rst_next = 1'b0;
        if (wr_acc && paddr == `PSML_REG_CTRL)
        begin
            full_rst_next = pwdata[`PSML_CTRL_RESET_BIT];
        end
    end

    always_comb
    begin
        strap_next = strap_reg;
        pend_next = 1'b0;
        if (full_rst_reg)
        begin
            pend_next = 1'b1;
        end
        if (pend_reg && !full_rst_reg)
        begin
            strap_next.byte_iface = byte_select;
            strap_next.oversample = {oversample_sel_2, oversample_sel_1,
                oversample_sel_0};
            strap_next.sw_mode = (range_mode_sel == 2'h0);
            strap_next.sw_range = range_mode_sel;
            strap_next.serial_mode = serial_mode_pin;
            strap_next.single_out = single_output_sel;
        end
    end

    // hardware mode follows the pins every cycle
    always_comb
    begin
        if (strap_reg.sw_mode)
        begin
            range_sel = psml_pkg::PSML_RANGE_SW;
        end
        else
        begin
            range_sel = psml_pkg::psml_range_t'(range_mode_sel);
        end
    end
    assign strap = strap_reg;

    // pins stay inputs until the straps are taken, else the device could
    // read back its own drive as a strap level
    assign pins_live = !full_rst_reg && !pend_reg;
    assign serial_act = pins_live && strap_reg.serial_mode
        && !strap_reg.byte_iface;
    assign fifo_out_ready = serial_act && (st_reg == psml_pkg::PSML_IDLE);

    always_comb
    begin
        st_next = st_reg;
        sh_next = sh_reg;
        bit_next = bit_reg;
        cfg_next = cfg_reg;
        unique case (st_reg)
            psml_pkg::PSML_IDLE:
            begin
                if (fifo_out_valid && fifo_out_ready)
                begin
                    sh_next = fifo_out_data;
                    bit_next = '0;
                    st_next = psml_pkg::PSML_SHIFT;
                end
            end
            psml_pkg::PSML_SHIFT:
            begin
                sh_next = {sh_reg[WORD_W-2:0], 1'b0};
                if (strap_reg.sw_mode)
                begin
                    cfg_next = {cfg_reg[WORD_W-2:0], serial_cfg_in};
                end
                bit_next = bit_reg + 1'b1;
                if (bit_reg == CW'(WORD_W - 1))
                begin
                    st_next = psml_pkg::PSML_IDLE;
                end
            end
        endcase
    end

    // pin routing: serial outputs only in serial mode, bus drive in parallel
    always_comb
    begin
        shared_out = '0;
        shared_oe = '0;
        if (pins_live && !strap_reg.serial_mode && !strap_reg.byte_iface)
        begin
            shared_out = par_wdata;
            shared_oe = {7{par_drive}};
        end
        else if (serial_act)
        begin
            shared_out[P_OUTA] = sh_reg[WORD_W-1];
            shared_oe[P_OUTA] = 1'b1;
            shared_out[P_OUTB] = sh_reg[WORD_W-1];
            shared_oe[P_OUTB] = !strap_reg.single_out;
        end
        // byte mode leaves serial pins undriven, board grounds them
    end

    always_comb
    begin
        prdata_next = prdata_reg;
        if (rd_acc)
        begin
            prdata_next = '0;
            unique case (paddr)
                `PSML_REG_STRAP:
                begin
                    prdata_next[`PSML_STRAP_BYTE_BIT] = strap_reg.byte_iface;
                    prdata_next[`PSML_STRAP_SW_BIT] = strap_reg.sw_mode;
                    prdata_next[`PSML_STRAP_ONE_BIT] = strap_reg.single_out;
                    prdata_next[`PSML_STRAP_OS_LSB +: 3] = strap_reg.oversample;
                    prdata_next[`PSML_STRAP_SER_BIT] = strap_reg.serial_mode;
                end
                `PSML_REG_RANGE: prdata_next[1:0] = range_sel;
                `PSML_REG_CFGIN: prdata_next[WORD_W-1:0] = cfg_reg;
                default: prdata_next = '0;
            endcase
        end
    end

    psml_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .in_valid(wr_acc && paddr == `PSML_REG_TXDATA),
        .in_ready(fifo_in_ready),
        .in_data(pwdata[WORD_W-1:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            full_rst_reg <= 1'b1;
            pend_reg <= 1'b1;
            strap_reg <= '0;
            st_reg <= psml_pkg::PSML_IDLE;
            sh_reg <= '0;
            bit_reg <= '0;
            cfg_reg <= '0;
            prdata_reg <= '0;
        end
        else if (ce)
        begin
            full_rst_reg <= full_rst_next;
            pend_reg <= pend_next;
            strap_reg <= strap_next;
            st_reg <= st_next;
            sh_reg <= sh_next;
            bit_reg <= bit_next;
            cfg_reg <= cfg_next;
            prdata_reg <= prdata_next;
        end
    end

    // one capture step: the cycle after the full reset flop drops
    sequence s_strap_take;
        ce && pend_reg && !full_rst_reg;
    endsequence

    a_strap_hold: assert property (@(posedge clk) disable iff (rst)
        ce && !pend_reg |=> strap_reg == $past(strap_reg))
        else $error("strap changed outside full reset");
    a_sw_decode: assert property (@(posedge clk) disable iff (rst)
        s_strap_take |=>
        strap_reg.sw_mode == ($past(range_mode_sel) == 2'h0))
        else $error("mode decode wrong");
    a_hw_live: assert property (@(posedge clk) disable iff (rst)
        !strap_reg.sw_mode |-> range_sel == range_mode_sel)
        else $error("hw range not live");
    a_outb_gate: assert property (@(posedge clk) disable iff (rst)
        serial_act && strap_reg.single_out |-> !shared_oe[P_OUTB])
        else $error("out b driven in single mode");
    a_outa_drive: assert property (@(posedge clk) disable iff (rst)
        serial_act |-> shared_oe[P_OUTA])
        else $error("out a not driven");
    a_par_drive: assert property (@(posedge clk) disable iff (rst)
        pins_live && !strap_reg.serial_mode && !strap_reg.byte_iface
        && par_drive |-> shared_oe == 7'h7F)
        else $error("parallel drive missing");
    a_byte_quiet: assert property (@(posedge clk) disable iff (rst)
        strap_reg.byte_iface |-> shared_oe == 7'h00)
        else $error("byte mode drives shared pins");
    a_os_latch: assert property (@(posedge clk) disable iff (rst)
        s_strap_take |=> strap_reg.oversample == $past(shared_in[6:4]))
        else $error("oversample not latched");
    a_byte_latch: assert property (@(posedge clk) disable iff (rst)
        s_strap_take |=> strap_reg.byte_iface == $past(byte_select))
        else $error("byte select not latched");
    a_pins_quiet: assert property (@(posedge clk) disable iff (rst)
        !pins_live |-> shared_oe == 7'h00)
        else $error("shared pins driven during full reset");
    a_sw_range: assert property (@(posedge clk) disable iff (rst)
        strap_reg.sw_mode |-> range_sel == psml_pkg::PSML_RANGE_SW)
        else $error("software mode range not ignored");
    a_cfg_shift: assert property (@(posedge clk) disable iff (rst)
        ce && st_reg == psml_pkg::PSML_SHIFT && strap_reg.sw_mode |=>
        cfg_reg[0] == $past(serial_cfg_in))
        else $error("config bit not shifted in");
endmodule : psml_top

// *** test/psml_host_model.sv ***
// host side of the shared strap pins: levels, grounding and wire resolution
`timescale 1ns/1ps
module psml_host_model (
    input wire logic host_byte,
    input wire logic [2:0] host_os,
    input wire logic host_cfg,
    input wire logic [6:0] shared_out,
    input wire logic [6:0] shared_oe,
    output logic [6:0] shared_in
);
    logic [6:0] host_lvl;
    always_comb
    begin
        host_lvl = {host_os, 2'h0, host_cfg, host_byte};
        // byte mode: serial pins held at digital ground
        if (host_byte)
        begin
            host_lvl[3:1] = 3'h0;
        end
        // a pin the device drives shows the device level on the wire
        for (int i = 0; i < 7; i++)
        begin
            shared_in[i] = shared_oe[i] ? shared_out[i] : host_lvl[i];
        end
    end
endmodule : psml_host_model

// *** test/tb_pin_strap_mode_latch.sv ***
// self-checking bench for the strap latch
`timescale 1ns/1ps
module tb_pin_strap_mode_latch;
    logic clk = 1'b0, rst = 1'b1, serial_mode_pin = 1'b1, par_drive = 1'b0;
    logic ce = 1'b1;
    logic [1:0] range_mode_sel = 2'h1;
    logic [6:0] shared_in, shared_out, shared_oe, par_wdata = 7'h01;
    logic host_byte = 1'b0, host_cfg = 1'b0;
    logic [2:0] host_os = 3'h5;
    psml_pkg::psml_range_t range_sel;
    psml_pkg::psml_strap_t strap;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int bad_count = 0, total_checks = 0, cyc = 0;
    always #2.5 clk = ~clk;
    psml_top i_psml_top (.clk(clk), .rst(rst), .ce(ce),
        .serial_mode_pin(serial_mode_pin), .range_mode_sel(range_mode_sel),
        .shared_in(shared_in), .shared_out(shared_out),
        .shared_oe(shared_oe), .par_wdata(par_wdata),
        .par_drive(par_drive), .range_sel(range_sel), .strap(strap),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    psml_host_model i_psml_host_model (.host_byte(host_byte),
        .host_os(host_os), .host_cfg(host_cfg), .shared_out(shared_out),
        .shared_oe(shared_oe), .shared_in(shared_in));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            finish_test;
        end
    end
    task cycles(input int n);
        repeat (n) @(posedge clk);
    endtask : cycles
    task do_reset;
        rst <= 1'b1;
        cycles(12);
        rst <= 1'b0;
        cycles(4);
    endtask : do_reset
    // one apb transfer; read data is taken at the edge pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task sc_hw_mode;
        do_reset;
        chk("oversample", strap.oversample, 3'h5);
        chk("sw_mode", strap.sw_mode, 1'b0);
        chk("byte_iface", strap.byte_iface, 1'b0);
        chk("single_out", strap.single_out, 1'b1);
        chk("serial_mode", strap.serial_mode, 1'b1);
        chk("out a on", shared_oe[3], 1'b1);
        chk("out b single", shared_oe[2], 1'b0);
        for (int r = 1; r < 4; r++)
        begin
            range_mode_sel <= r[1:0];
            cycles(2);
            chk("range_sel", range_sel, r[1:0]);
        end
        host_os <= 3'h2;
        range_mode_sel <= 2'h2;
        cycles(3);
        chk("os held", strap.oversample, 3'h5);
        chk("range live", range_sel, 2'h2);
    endtask : sc_hw_mode
    task sc_sw_mode;
        range_mode_sel <= 2'h0;
        host_byte <= 1'b1;
        do_reset;
        chk("sw_mode", strap.sw_mode, 1'b1);
        chk("byte_iface", strap.byte_iface, 1'b1);
        range_mode_sel <= 2'h3;
        cycles(3);
        chk("range ignored", range_sel, 2'h0);
        chk("sw_range", strap.sw_range, 2'h0);
        apb(1'b0, 12'hFFC, 32'h0);
        chk("unmapped", rd, 32'h0);
        // software full reset re-latches the byte strap
        host_byte <= 1'b0;
        range_mode_sel <= 2'h1;
        apb(1'b1, 12'h000, 32'h1);
        cycles(6);
        chk("byte relatch", strap.byte_iface, 1'b0);
        chk("hw relatch", strap.sw_mode, 1'b0);
    endtask : sc_sw_mode
    task sc_parallel;
        serial_mode_pin <= 1'b0;
        par_drive <= 1'b1;
        par_wdata <= 7'h5A;
        do_reset;
        chk("par oe", shared_oe, 7'h7F);
        chk("par data", shared_out, 7'h5A);
        par_drive <= 1'b0;
    endtask : sc_parallel
    task sc_serial;
        logic [15:0] wa, wb;
        int n;
        serial_mode_pin <= 1'b1;
        par_wdata <= 7'h00;
        do_reset;
        apb(1'b1, 12'h00C, 32'h0000B38E);
        n = 0;
        // idle line is low and the word opens with a one: sync on it
        @(negedge clk);
        while (shared_out[3] !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        chk("out a drive", shared_oe[3], 1'b1);
        chk("out b drive", shared_oe[2], 1'b1);
        for (int i = 15; i >= 0; i--)
        begin
            wa[i] = shared_out[3];
            wb[i] = shared_out[2];
            @(negedge clk);
        end
        chk("out a word", wa, 16'hB38E);
        chk("out b word", wb, 16'hB38E);
        @(posedge clk);
    endtask : sc_serial
    task sc_sw_serial;
        range_mode_sel <= 2'h0;
        host_cfg <= 1'b1;
        do_reset;
        apb(1'b1, 12'h00C, 32'h00001234);
        cycles(24);
        apb(1'b0, 12'h010, 32'h0);
        chk("cfg in", rd, 32'h0000FFFF);
        apb(1'b0, 12'h004, 32'h0);
        chk("strap reg", rd, 32'h00000122);
        apb(1'b0, 12'h008, 32'h0);
        chk("range reg", rd, 32'h0);
    endtask : sc_sw_serial
    task sc_clock_enable;
        ce <= 1'b0;
        host_os <= 3'h7;
        do_reset;
        chk("frozen os", strap.oversample, 3'h0);
        ce <= 1'b1;
        cycles(4);
        chk("os after ce", strap.oversample, 3'h7);
    endtask : sc_clock_enable
    initial
    begin
        sc_hw_mode;
        sc_sw_mode;
        sc_parallel;
        sc_serial;
        sc_sw_serial;
        sc_clock_enable;
        finish_test;
    end
endmodule : tb_pin_strap_mode_latch
